// File: verilog/pab_pin_mux.sv
// pin function mux for port a pins 2..0 and port b pins 7..3
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// ------------------------------------------------------------------

module pab_pin_mux
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire pab_pkg::pab_lcd_ctl_t lcd_port_control_register,
  input  wire logic [2:0]            port_a_direction_register,
  input  wire logic [2:0]            port_a_data,
  input  wire logic [2:0]            lcd_common_wave,
  input  wire logic [2:0]            port_a_pin_in,
  input  wire logic [3:0]            converter_channel_field,
  input  wire logic [7:3]            port_b_pin_in,
  output var  logic [2:0]            port_a_pin_out,
  output var  logic [2:0]            port_a_pin_oe,
  output var  logic [2:0]            port_a_read,
  output var  logic [2:0]            port_a_com_active,
  output var  logic [7:3]            port_b_read,
  output var  logic [7:3]            port_b_analog_sel
);
  import pab_pkg::*;

  logic                 gpio_mode;
  logic [2:0]           mux_bits;
  pab_pa_fn_t [2:0]     fn_next;
  logic [2:0]           out_next;
  logic [2:0]           oe_next;
  logic [2:0]           read_next;

  // ------------------------------------------------------------------
  // port a function decode
  // ------------------------------------------------------------------
  assign gpio_mode = (lcd_port_control_register.lcd_segment_select_field == PAB_SEG_GPIO);
  assign mux_bits  = {lcd_port_control_register.lcd_duty_select_high,
                      lcd_port_control_register.lcd_duty_select_low,
                      lcd_port_control_register.lcd_common_mux_select};

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      fn_next[i] = port_a_direction_register[i] ? PAB_FN_OUT : PAB_FN_IN;
    end
    if (!gpio_mode)
    begin
      fn_next[0] = PAB_FN_COM;
      fn_next[1] = (mux_bits == PAB_MUX_NONE) ? PAB_FN_OPEN : PAB_FN_COM;
      fn_next[2] = ((mux_bits == PAB_MUX_NONE) || (mux_bits == PAB_MUX_NO_LCD_COMMON_OUT_THREE))
                   ? PAB_FN_OPEN : PAB_FN_COM;
    end
  end

  // an open pin is simply not driven; its level is left floating
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      case (fn_next[i])
        PAB_FN_OUT:
        begin
          out_next[i]  = port_a_data[i];
          oe_next[i]   = 1'b1;
          read_next[i] = port_a_data[i];
        end
        PAB_FN_COM:
        begin
          out_next[i]  = lcd_common_wave[i];
          oe_next[i]   = 1'b1;
          read_next[i] = 1'b0;
        end
        PAB_FN_IN:
        begin
          out_next[i]  = 1'b0;
          oe_next[i]   = 1'b0;
          read_next[i] = port_a_pin_in[i];
        end
        default:
        begin
          out_next[i]  = 1'b0;
          oe_next[i]   = 1'b0;
          read_next[i] = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // port a output registers
  // ------------------------------------------------------------------
  // one register stage keeps pin timing clean; new settings show one
  // clock later with no further software action
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      port_a_pin_out    <= PAB_PA_RST;
      port_a_pin_oe     <= PAB_PA_RST;
      port_a_read       <= PAB_PA_RST;
      port_a_com_active <= PAB_PA_RST;
    end
    else
    begin
      port_a_pin_out <= out_next;
      port_a_pin_oe  <= oe_next;
      port_a_read    <= read_next;
      for (int i = 0; i < 3; i++)
      begin
        port_a_com_active[i] <= (fn_next[i] == PAB_FN_COM);
      end
    end
  end

  // ------------------------------------------------------------------
  // port b cells
  // ------------------------------------------------------------------
  for (genvar g = 0; g < 5; g++)
  begin : g_pb
    pab_pb_cell
    #(
      .CODE (PAB_PB_CODE[g])
    )
    u_cell
    (
      .clock         (clock),
      .rst           (rst),
      .channel_field (converter_channel_field),
      .pin_in        (port_b_pin_in[g+3]),
      .analog_en_reg (port_b_analog_sel[g+3]),
      .gp_read_reg   (port_b_read[g+3])
    );
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_pa2_gpio;
    @(posedge clock) disable iff (rst)
    gpio_mode |=> (port_a_pin_oe[2] == $past(port_a_direction_register[2]))
                  && !port_a_com_active[2];
  endproperty
  a_pa2_gpio: assert property (p_pa2_gpio) else $error("pin 2 gpio direction wrong");

  property p_pa2_open;
    @(posedge clock) disable iff (rst)
    (!gpio_mode && (mux_bits == 3'h0 || mux_bits == 3'h2))
      |=> !port_a_pin_oe[2] && !port_a_com_active[2];
  endproperty
  a_pa2_open: assert property (p_pa2_open) else $error("pin 2 not left open");

  property p_pa2_com;
    @(posedge clock) disable iff (rst)
    (!gpio_mode && mux_bits != 3'h0 && mux_bits != 3'h2)
      |=> port_a_com_active[2] && port_a_pin_oe[2]
          && (port_a_pin_out[2] == $past(lcd_common_wave[2]));
  endproperty
  a_pa2_com: assert property (p_pa2_com) else $error("pin 2 not common three");

  property p_pa1_gpio;
    @(posedge clock) disable iff (rst)
    (gpio_mode && port_a_direction_register[1])
      |=> port_a_pin_oe[1] && (port_a_pin_out[1] == $past(port_a_data[1]));
  endproperty
  a_pa1_gpio: assert property (p_pa1_gpio) else $error("pin 1 output wrong");

  property p_pa1_com;
    @(posedge clock) disable iff (rst)
    !gpio_mode |=> port_a_com_active[1] == ($past(mux_bits) != 3'h0);
  endproperty
  a_pa1_com: assert property (p_pa1_com) else $error("pin 1 common select wrong");

  property p_pa0_gpio;
    @(posedge clock) disable iff (rst)
    (gpio_mode && !port_a_direction_register[0])
      |=> !port_a_pin_oe[0] && (port_a_read[0] == $past(port_a_pin_in[0]));
  endproperty
  a_pa0_gpio: assert property (p_pa0_gpio) else $error("pin 0 input wrong");

  property p_pa0_com;
    @(posedge clock) disable iff (rst)
    !gpio_mode |=> port_a_com_active[0] && port_a_pin_oe[0];
  endproperty
  a_pa0_com: assert property (p_pa0_com) else $error("pin 0 not common one");

  property p_pb7;
    @(posedge clock) disable iff (rst)
    1'b1 |=> port_b_analog_sel[7] == ($past(converter_channel_field) == 4'hB);
  endproperty
  a_pb7: assert property (p_pb7) else $error("pin b7 routing wrong");

  property p_pb6;
    @(posedge clock) disable iff (rst)
    (converter_channel_field == 4'hA) |=> port_b_analog_sel[6] && !port_b_read[6];
  endproperty
  a_pb6: assert property (p_pb6) else $error("pin b6 routing wrong");

  property p_pb5;
    @(posedge clock) disable iff (rst)
    (converter_channel_field != 4'h9)
      |=> !port_b_analog_sel[5] && (port_b_read[5] == $past(port_b_pin_in[5]));
  endproperty
  a_pb5: assert property (p_pb5) else $error("pin b5 input wrong");

  property p_pb4;
    @(posedge clock) disable iff (rst)
    1'b1 |=> port_b_analog_sel[4] == ($past(converter_channel_field) == 4'h8);
  endproperty
  a_pb4: assert property (p_pb4) else $error("pin b4 routing wrong");

  property p_pb3;
    @(posedge clock) disable iff (rst)
    1'b1 |=> port_b_analog_sel[3] == ($past(converter_channel_field) == 4'h7);
  endproperty
  a_pb3: assert property (p_pb3) else $error("pin b3 routing wrong");

  property p_follow;
    @(posedge clock) disable iff (rst)
    (!gpio_mode ##1 gpio_mode)
      |=> !port_a_com_active[0] && (port_a_pin_oe == $past(port_a_direction_register));
  endproperty
  a_follow: assert property (p_follow) else $error("pin function lagged control");

endmodule

`default_nettype wire

// File: verilog/pab_pkg.sv
// shared constants and types for the port a/b pin function mux
package pab_pkg;

  // ----------------------------------------------------------------
  // control codes
  // ----------------------------------------------------------------
  localparam logic [3:0] PAB_SEG_GPIO     = 4'h0;
  localparam logic [2:0] PAB_MUX_NONE     = 3'h0;
  localparam logic [2:0] PAB_MUX_NO_LCD_COMMON_OUT_THREE  = 3'h2;

  // converter channel code per port b pin, index 0 is pin 3, index 4 is pin 7
  localparam logic [4:0][3:0] PAB_PB_CODE = {4'hB, 4'hA, 4'h9, 4'h8, 4'h7};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] PAB_PA_RST = 3'h0;
  localparam logic       PAB_PB_RST = 1'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PAB_FN_IN   = 2'h0,
    PAB_FN_OUT  = 2'h1,
    PAB_FN_COM  = 2'h3,
    PAB_FN_OPEN = 2'h2
  } pab_pa_fn_t;

  typedef struct packed {
    logic [3:0] lcd_segment_select_field;
    logic       lcd_duty_select_high;
    logic       lcd_duty_select_low;
    logic       lcd_common_mux_select;
  } pab_lcd_ctl_t;

endpackage

// File: verilog/pab_pb_cell.sv
// one port b pin: general input or converter channel
`timescale 1ns/10ps
`default_nettype none

module pab_pb_cell
#(
  parameter logic [3:0] CODE = 4'h0
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] channel_field,
  input  wire logic       pin_in,
  output var  logic       analog_en_reg,
  output var  logic       gp_read_reg
);
  import pab_pkg::*;

  logic analog_next;

  // ----------------------------------------------------------------
  // function select
  // ----------------------------------------------------------------
  assign analog_next = (channel_field == CODE);

  // digital read is forced low while the converter owns the pin,
  // so a floating analog level never reaches the data path
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      analog_en_reg <= PAB_PB_RST;
      gp_read_reg   <= PAB_PB_RST;
    end
    else
    begin
      analog_en_reg <= analog_next;
      gp_read_reg   <= pin_in & ~analog_next;
    end
  end

endmodule

`default_nettype wire

// File: bench/pab_board_model.sv
// board model: signal sources and floating levels on the port a pins
`timescale 1ns/10ps
`default_nettype none

module pab_board_model
(
  input  wire logic       clock,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] src_level,
  input  wire logic [2:0] src_drive,
  output var  logic [2:0] pin_level
);
  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // a floating pin wanders each cycle, so no one can lean on its last level
  logic [2:0] float_reg = 3'h5;

  always @(posedge clock)
  begin
    float_reg <= ~float_reg;
  end

  assign pin_level = (pin_oe & pin_out) | (~pin_oe & src_drive & src_level)
                   | (~pin_oe & ~src_drive & float_reg);
endmodule

`default_nettype wire

// File: bench/port_ab_pin_function_mux_tb_top.sv
// self-checking bench for the port a/b pin function mux
`timescale 1ns/10ps
`default_nettype none

module port_ab_pin_function_mux_tb_top;
  import pab_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic          clock = 1'h0;
  logic          rst   = 1'h1;
  pab_lcd_ctl_t  ctl   = '0;
  logic [2:0]    dir   = 3'h0;
  logic [2:0]    data  = 3'h0;
  logic [2:0]    wave  = 3'h0;
  logic [2:0]    ext   = 3'h0;
  logic [2:0]    sdrv  = 3'h0;
  logic [3:0]    chan  = 4'h0;
  logic [7:3]    pbin  = 5'h00;
  logic [2:0]    pa_in, pa_out, pa_oe, pa_rd, pa_com;
  logic [7:3]    pb_rd, pb_sel, sel;
  logic [2:0]    com;
  int            err_count = 0;
  int            checks = 0;
  int            cycles = 0;

  pab_pin_mux u_dut (.clock(clock), .rst(rst), .lcd_port_control_register(ctl),
    .port_a_direction_register(dir), .port_a_data(data), .lcd_common_wave(wave),
    .port_a_pin_in(pa_in), .converter_channel_field(chan), .port_b_pin_in(pbin),
    .port_a_pin_out(pa_out), .port_a_pin_oe(pa_oe), .port_a_read(pa_rd),
    .port_a_com_active(pa_com), .port_b_read(pb_rd), .port_b_analog_sel(pb_sel));

  pab_board_model u_board (.clock(clock), .pin_oe(pa_oe), .pin_out(pa_out),
    .src_level(ext), .src_drive(sdrv), .pin_level(pa_in));

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // pin reads loop back through the board, so gpio waits out one extra edge
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_gpio;
    for (int d = 0; d < 8; d++)
    begin
      @(posedge clock);
      ctl  <= {4'h0, 3'h7};
      dir  <= d[2:0];
      data <= 3'h5 ^ d[2:0];
      ext  <= 3'h3;
      sdrv <= 3'h7;
      settle(2);
      check(8'(pa_oe), 8'(d[2:0]));
      check(8'(pa_out), 8'(d[2:0] & (3'h5 ^ d[2:0])));
      check(8'(pa_rd), 8'((d[2:0] & (3'h5 ^ d[2:0])) | (~d[2:0] & 3'h3)));
      check(8'(pa_com), 8'h00);
    end
  endtask

  task automatic t_lcd;
    for (int m = 0; m < 8; m++)
    begin
      @(posedge clock);
      ctl  <= {(m[0] ? 4'hF : 4'h1), m[2:0]};
      dir  <= ~m[2:0];
      data <= 3'h7;
      wave <= m[0] ? 3'h5 : 3'h2;
      sdrv <= 3'h0;
      settle(1);
      com = {m != 0 && m != 2, m != 0, 1'b1};
      check(8'(pa_com), 8'(com));
      check(8'(pa_oe), 8'(com));
      check(8'(pa_out), 8'(com & (m[0] ? 3'h5 : 3'h2)));
      check(8'(pa_rd), 8'h00);
    end
  endtask

  // one edge of latency exactly: a control change shows at the next edge
  task automatic t_adc;
    for (int c = 0; c < 16; c++)
    begin
      @(posedge clock);
      chan <= c[3:0];
      pbin <= 5'h15 ^ c[4:0];
      settle(1);
      for (int i = 0; i < 5; i++)
        sel[i + 3] = (c == i + 7);
      check(8'(pb_sel), 8'(sel));
      check(8'(pb_rd), 8'((5'h15 ^ c[4:0]) & ~sel));
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    check({2'h0, pa_oe, pa_out}, 8'h00);
    check({pb_sel, pa_com}, 8'h00);
    check({pb_rd, pa_rd}, 8'h00);
    rst <= 1'h0;
    t_gpio();
    t_lcd();
    t_adc();
    t_gpio();
    conclude();
  end
endmodule

`default_nettype wire
